// [rtl/csr_params.svh]
// Constants for the control signal routing block
// Operation
// - Each signal from any input, Low or High
// - Each routed signal individually invertible
// - Slot setting decides inputs three to seven
// - Slot mismatch raises error indication
// - Digital inputs readable by host as masked by slot setting
// - Pulse mode toggles standby latch per rising edge
// - Serial depth 2-5 ORs host signals in
// - Computer operation gates serial signals
// - Host toggles local latch at depth 2-5
// - Standby OR at depth 2/4, AND at 3/5
// - Serial depth picks setpoint and tracking source
// - Types 5/6 lock serial when not computer
// - Static mode; lamp lit when standby low
// - Active-low ready and operation messages
// - Acknowledge mode sets local latch on recovery
// - Key lock 0/2 fixes internal or external
// - Manual is key latch OR external manual
// - Manual key modes 1/2 block front switching
// - Levels at 0-2, edge toggles at 3/4
// - Mode 4 releases serial manual gating
// - External manual freezes automatic output
// - Lock signals block configuration and panel
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CSR_A_CFG0 4'h0
`define CSR_A_CFG1 4'h1
`define CSR_A_POL 4'h2
`define CSR_A_SER 4'h3
`define CSR_A_STAT 4'h4
`define CSR_A_DIN 4'h5
`define CSR_A_KEY 4'h6
// ----------------------------------------------------------------
// Selector codes and field positions
// ----------------------------------------------------------------
`define CSR_SEL_LOW 4'h0
`define CSR_SEL_HIGH 4'h8
`define CSR_NSIG 8
`define CSR_NDI 7
`define CSR_SIG_CB 0
`define CSR_SIG_HE 1
`define CSR_SIG_P 2
`define CSR_SIG_LS 3
`define CSR_SIG_LPS 4
`define CSR_SIG_LB 5
`define CSR_SIG_PU 6
`define CSR_SIG_TSH 7
`define CSR_KL_INT 2'h0
`define CSR_KL_FREE 2'h1
`define CSR_KL_EXT 2'h2
`define CSR_MK_AUTO 3'h1
`define CSR_MK_MAN 3'h2
`define CSR_MK_EDGE 3'h3
`define CSR_MK_EDGE_FREE 3'h4
`endif

// [rtl/csr_pkg.sv]
// Types for the control signal routing block
package csr_pkg;
  typedef struct packed {
    logic [6:0] din;
    logic key_local;
    logic key_manual;
    logic [1:0] slot_fitted;
    logic [2:0] ctrl_type;
  } csr_field_t;
  typedef struct packed {
    logic standby_request;
    logic computer_operation;
    logic computer_ready_msg_n;
    logic computer_operation_msg_n;
    logic standby_lamp;
    logic internal_lamp;
    logic manual_mode;
    logic output_freeze;
    logic p_operation;
    logic setpoint_program_select;
    logic setpoint_change_hold;
    logic lock_structuring;
    logic lock_param_and_struct;
    logic lock_front_panel;
    logic setpoint_from_serial;
    logic tracking_from_serial;
    logic serial_locked;
    logic slot_error;
  } csr_ctl_t;
  typedef struct packed {
    logic [1:0] din_s1;
    logic [6:0] di_m;
    logic [6:0] di_s;
    logic [6:0] di_d;
    logic [1:0] kl_m;
    logic [1:0] kl_s;
    logic [1:0] kl_d;
    logic [1:0] slot_m;
    logic [1:0] slot_s;
    logic [2:0] type_m;
    logic [2:0] type_s;
    logic [31:0] sel;
    logic [7:0] pol;
    logic [1:0] slot_sel;
    logic stby_mode;
    logic [1:0] key_lock;
    logic [2:0] man_mode;
    logic [2:0] ser_depth;
    logic [7:0] ser;
    logic ser_int_t;
    logic ser_int_d;
    logic cb_pulse;
    logic cb_d;
    logic he_d;
    logic he_tgl;
    logic local_l;
    logic man_l;
    logic strap_done;
    logic ack;
    logic [31:0] dat;
    csr_ctl_t ctl;
  } csr_state_t;
endpackage

// [rtl/csr_routing.sv]
// Control signal routing with Wishbone configuration port
`timescale 1ns/10ps
`include "csr_params.svh"
module csr_routing (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input csr_pkg::csr_field_t field_i,
  output csr_pkg::csr_ctl_t ctl_o
);
  import csr_pkg::*;

  csr_state_t s_r, s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pick(input logic [3:0] code, input logic [6:0] di);
    logic r;
    r = 1'b0;
    if (code == `CSR_SEL_HIGH) begin
      r = 1'b1;
    end else if (code != `CSR_SEL_LOW && code < `CSR_SEL_HIGH) begin
      r = di[code[2:0] - 3'h1];
    end
    return r;
  endfunction

  function automatic logic [1:0] rise(input logic [1:0] now, input logic [1:0] was);
    return now & ~was;
  endfunction

  logic [6:0] di_av;
  logic [7:0] sig_di;
  logic [7:0] sig_eff;
  logic cb_di;
  logic cb;
  logic rc;
  logic ser_on;
  logic he_ser;
  logic he_lvl;
  logic he_edge;
  logic key_loc_edge;
  logic key_man_edge;
  logic int_edge;
  logic wr;
  logic [3:0] ra;

  always_comb begin
    s_nxt = s_r;
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    s_nxt.di_m = field_i.din;
    s_nxt.di_s = s_r.di_m;
    s_nxt.di_d = s_r.di_s;
    s_nxt.kl_m = {field_i.key_local, field_i.key_manual};
    s_nxt.kl_s = s_r.kl_m;
    s_nxt.kl_d = s_r.kl_s;
    s_nxt.slot_m = field_i.slot_fitted;
    s_nxt.slot_s = s_r.slot_m;
    s_nxt.type_m = field_i.ctrl_type;
    s_nxt.type_s = s_r.type_m;
    s_nxt.din_s1 = 2'h0;
    // ----------------------------------------------------------------
    // Input availability and selection
    // ----------------------------------------------------------------
    di_av = s_r.di_s;
    if (s_r.slot_sel == 2'h0) begin
      di_av[6:2] = 5'h00;
    end else if (s_r.slot_sel == 2'h1) begin
      di_av[6:4] = 3'h0;
    end
    for (int i = 0; i < `CSR_NSIG; i++) begin
      sig_di[i] = pick(s_r.sel[i*4 +: 4], di_av) ^ s_r.pol[i];
    end
    // Standby pulse latch
    // Latch idles low in static mode
    s_nxt.cb_d = sig_di[`CSR_SIG_CB];
    if (!s_r.stby_mode) begin
      s_nxt.cb_pulse = 1'b0;
    end else if (sig_di[`CSR_SIG_CB] && !s_r.cb_d) begin
      s_nxt.cb_pulse = ~s_r.cb_pulse;
    end
    cb_di = s_r.stby_mode ? s_r.cb_pulse : sig_di[`CSR_SIG_CB];
    // ----------------------------------------------------------------
    // Serial combining
    // ----------------------------------------------------------------
    ser_on = s_r.ser_depth == 3'h2 || s_r.ser_depth == 3'h3 ||
             s_r.ser_depth == 3'h4 || s_r.ser_depth == 3'h5;
    cb = cb_di;
    if (s_r.ser_depth == 3'h2 || s_r.ser_depth == 3'h4) begin
      cb = cb_di | s_r.ser[`CSR_SIG_CB];
    end else if (s_r.ser_depth == 3'h3 || s_r.ser_depth == 3'h5) begin
      cb = cb_di & s_r.ser[`CSR_SIG_CB];
    end
    rc = ~s_r.local_l & cb;
    for (int i = 0; i < `CSR_NSIG; i++) begin
      sig_eff[i] = sig_di[i] | (ser_on & rc & s_r.ser[i]);
    end
    he_ser = ser_on & s_r.ser[`CSR_SIG_HE] & (rc | s_r.man_mode == `CSR_MK_EDGE_FREE);
    he_lvl = sig_di[`CSR_SIG_HE] | he_ser;
    sig_eff[`CSR_SIG_CB] = cb;
    // ----------------------------------------------------------------
    // Local/remote latch
    // ----------------------------------------------------------------
    key_loc_edge = rise(s_r.kl_s, s_r.kl_d) != 2'h0 && s_r.kl_s[1] && !s_r.kl_d[1];
    key_man_edge = s_r.kl_s[0] && !s_r.kl_d[0];
    s_nxt.ser_int_d = s_r.ser_int_t;
    int_edge = ser_on && (s_r.ser_int_t != s_r.ser_int_d);
    s_nxt.ctl.standby_request = cb;
    // Fixed key lock wins over acknowledge
    if (s_r.key_lock == `CSR_KL_INT) begin
      s_nxt.local_l = 1'b1;
    end else if (s_r.key_lock == `CSR_KL_EXT) begin
      s_nxt.local_l = 1'b0;
    end else if (s_r.stby_mode && cb && !s_r.ctl.standby_request) begin
      s_nxt.local_l = 1'b1;
    end else if (key_loc_edge ^ int_edge) begin
      s_nxt.local_l = ~s_r.local_l;
    end
    // ----------------------------------------------------------------
    // Manual/automatic
    // ----------------------------------------------------------------
    s_nxt.he_d = he_lvl;
    he_edge = he_lvl && !s_r.he_d;
    if (s_r.man_mode == `CSR_MK_AUTO) begin
      s_nxt.man_l = 1'b0;
    end else if (s_r.man_mode == `CSR_MK_MAN) begin
      s_nxt.man_l = 1'b1;
    end else if (key_man_edge) begin
      s_nxt.man_l = ~s_r.man_l;
    end
    if (s_r.man_mode >= `CSR_MK_EDGE && he_edge) begin
      s_nxt.he_tgl = ~s_r.he_tgl;
    end
    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    s_nxt.ctl.computer_operation = rc;
    s_nxt.ctl.computer_ready_msg_n = s_r.local_l;
    s_nxt.ctl.computer_operation_msg_n = ~rc;
    s_nxt.ctl.standby_lamp = ~cb;
    s_nxt.ctl.internal_lamp = s_r.local_l;
    s_nxt.ctl.manual_mode = s_r.man_l |
      (s_r.man_mode >= `CSR_MK_EDGE ? s_r.he_tgl : he_lvl);
    s_nxt.ctl.output_freeze = s_r.man_mode >= `CSR_MK_EDGE ? s_r.he_tgl : he_lvl;
    s_nxt.ctl.p_operation = sig_eff[`CSR_SIG_P];
    s_nxt.ctl.setpoint_program_select = sig_eff[`CSR_SIG_PU];
    s_nxt.ctl.setpoint_change_hold = sig_eff[`CSR_SIG_TSH];
    s_nxt.ctl.lock_structuring = sig_eff[`CSR_SIG_LS];
    s_nxt.ctl.lock_param_and_struct = sig_eff[`CSR_SIG_LPS];
    s_nxt.ctl.lock_front_panel = sig_eff[`CSR_SIG_LB];
    s_nxt.ctl.setpoint_from_serial = s_r.ser_depth == 3'h2 || s_r.ser_depth == 3'h3;
    s_nxt.ctl.tracking_from_serial = s_r.ser_depth == 3'h2 || s_r.ser_depth == 3'h3;
    s_nxt.ctl.serial_locked = (s_r.type_s == 3'h5 || s_r.type_s == 3'h6) &&
                              (s_r.local_l || !cb);
    s_nxt.ctl.slot_error = s_r.slot_s != s_r.slot_sel;
    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    ra = wb_adr_i[5:2];
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_r.ack && wb_sel_i == 4'hf;
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.dat = 32'h0;
    unique case (ra)
      `CSR_A_CFG0: s_nxt.dat = s_r.sel;
      `CSR_A_CFG1: s_nxt.dat = {16'h0, 1'b0, s_r.ser_depth, 1'b0, s_r.man_mode,
                                s_r.key_lock, s_r.slot_sel, 3'h0, s_r.stby_mode};
      `CSR_A_POL: s_nxt.dat = {24'h0, s_r.pol};
      `CSR_A_SER: s_nxt.dat = {23'h0, s_r.ser_int_t, s_r.ser};
      `CSR_A_STAT: s_nxt.dat = {14'h0, s_r.ctl};
      `CSR_A_DIN: s_nxt.dat = {25'h0, di_av};
      `CSR_A_KEY: s_nxt.dat = {28'h0, s_r.local_l, s_r.man_l, s_r.cb_pulse, s_r.he_tgl};
      default: s_nxt.dat = 32'h0;
    endcase
    if (wr) begin
      unique case (ra)
        `CSR_A_CFG0: s_nxt.sel = wb_dat_i;
        `CSR_A_CFG1: begin
          s_nxt.stby_mode = wb_dat_i[0];
          s_nxt.slot_sel = wb_dat_i[5:4];
          s_nxt.key_lock = wb_dat_i[7:6];
          s_nxt.man_mode = wb_dat_i[10:8];
          s_nxt.ser_depth = wb_dat_i[14:12];
        end
        `CSR_A_POL: s_nxt.pol = wb_dat_i[7:0];
        `CSR_A_SER: begin
          s_nxt.ser = wb_dat_i[7:0];
          if (wb_dat_i[8]) begin
            s_nxt.ser_int_t = ~s_r.ser_int_t;
          end
        end
        default: ;
      endcase
    end
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.sel = {28'h0, `CSR_SEL_HIGH};
      s_nxt.local_l = 1'b1;
      s_nxt.ctl.computer_ready_msg_n = 1'b1;
      s_nxt.ctl.computer_operation_msg_n = 1'b1;
      s_nxt.ctl.internal_lamp = 1'b1;
      s_nxt.ctl.standby_lamp = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign ctl_o = s_r.ctl;
endmodule

// [verification/csr_routing_asserts.sv]
// Checker on the routing block ports
`timescale 1ns/10ps
module csr_routing_asserts
  import csr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire csr_pkg::csr_ctl_t ctl_o
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ready_msg_a: assert property (ctl_o.computer_ready_msg_n == ctl_o.internal_lamp)
    else $error("ready message wrong");
  op_msg_a: assert property (ctl_o.computer_operation_msg_n != ctl_o.computer_operation)
    else $error("operation message wrong");
  comp_op_a: assert property (ctl_o.computer_operation ==
    (ctl_o.standby_request && !ctl_o.internal_lamp)) else $error("computer operation wrong");
  stby_lamp_a: assert property (ctl_o.standby_lamp != ctl_o.standby_request)
    else $error("standby lamp wrong");
  freeze_man_a: assert property (ctl_o.output_freeze |-> ctl_o.manual_mode)
    else $error("freeze outside manual");
  src_pair_a: assert property (ctl_o.setpoint_from_serial == ctl_o.tracking_from_serial)
    else $error("source select split");
endmodule

// [verification/csr_field_model.sv]
// Field side model: inputs, front keys, fitted module
`timescale 1ns/10ps
module csr_field_model
  import csr_pkg::*;
(
  input wire logic clk,
  output csr_pkg::csr_field_t field_o
);
  initial field_o = '0;
  // Level changes on field pins
  task automatic set_din(input logic [6:0] v);
    field_o.din <= v;
  endtask
  task automatic set_slot(input logic [1:0] v);
    field_o.slot_fitted <= v;
  endtask
  task automatic set_type(input logic [2:0] v);
    field_o.ctrl_type <= v;
  endtask
  // Key held for several cycles like a real press
  task automatic press(input logic man);
    @(posedge clk);
    field_o.key_manual <= man;
    field_o.key_local <= !man;
    repeat (5) @(posedge clk);
    field_o.key_manual <= 1'b0;
    field_o.key_local <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the routing block
`timescale 1ns/10ps
module testbench;
  import csr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  csr_field_t fld;
  csr_ctl_t ctl;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'hb47450a0;
  logic [31:0] sel;
  logic [7:0] pol;
  logic [6:0] din;
  logic [7:0] want;
  always #25 clk = ~clk;
  csr_field_model field (.clk(clk), .field_o(fld));
  csr_routing dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .field_i(fld), .ctl_o(ctl));
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic wt();
    repeat (8) @(posedge clk);
  endtask
  function automatic logic route(input logic [3:0] c, input logic [6:0] d, input logic p);
    return ((c == 4'h0) ? 1'b0 : (c >= 4'h8) ? 1'b1 : d[c - 4'h1]) ^ p;
  endfunction
  function automatic logic [7:0] sigs(input csr_ctl_t c);
    return {c.setpoint_change_hold, c.setpoint_program_select, c.lock_front_panel,
      c.lock_param_and_struct, c.lock_structuring, c.p_operation, c.manual_mode,
      c.standby_request};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    check("reset ctl", {14'h0, ctl}, 32'h0000f000);
    rst_n <= 1'b1;
    field.set_slot(2'h2);
    bus(1'b0, 4'h0, 32'h0);
    check("sel reset", rd, 32'h00000008);
    bus(1'b1, 4'hf, 32'hffffffff);
    bus(1'b0, 4'hf, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("reset test done");
    for (int s = 0; s < 3; s++) begin
      din = 7'($random(seed));
      field.set_din(din);
      bus(1'b1, 4'h1, 32'h40 | (s << 4));
      wt();
      bus(1'b0, 4'h5, 32'h0);
      check("din", rd, {25'h0, din & (s == 2 ? 7'h7f : s == 1 ? 7'h0f : 7'h03)});
      check("slot err", ctl.slot_error, s != 2);
    end
    $display("input test done");
    for (int k = 0; k < 12; k++) begin
      for (int i = 0; i < 8; i++) sel[4*i +: 4] = 4'($unsigned($random(seed)) % 9);
      pol = 8'($random(seed));
      din = 7'($random(seed));
      field.set_din(din);
      bus(1'b1, 4'h0, sel);
      bus(1'b1, 4'h2, {24'h0, pol});
      wt();
      for (int i = 0; i < 8; i++) want[i] = route(sel[4*i +: 4], din, pol[i]);
      check("routed", sigs(ctl), want);
    end
    $display("routing test done");
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h8);
    bus(1'b1, 4'h1, 32'h2060);
    bus(1'b1, 4'h3, 32'h108);
    wt();
    check("local", ctl.internal_lamp, 1'b0);
    check("ser ls", ctl.lock_structuring, 1'b1);
    check("sp src", ctl.setpoint_from_serial, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    wt();
    check("gated", ctl.lock_structuring, 1'b0);
    bus(1'b1, 4'h3, 32'h9);
    wt();
    check("cb or", ctl.standby_request, 1'b1);
    bus(1'b1, 4'h1, 32'h3061);
    wt();
    check("cb and", ctl.standby_request, 1'b0);
    field.set_type(3'h5);
    bus(1'b1, 4'h0, 32'h8);
    wt();
    check("pulse", ctl.standby_request, 1'b1);
    check("ack set", ctl.internal_lamp, 1'b1);
    check("ser lock", ctl.serial_locked, 1'b1);
    bus(1'b1, 4'h1, 32'ha0);
    wt();
    check("kl ext", ctl.internal_lamp, 1'b0);
    bus(1'b1, 4'h1, 32'h20);
    wt();
    check("kl int", ctl.internal_lamp, 1'b1);
    $display("serial test done");
    field.set_din(7'h0);
    bus(1'b1, 4'h0, 32'h18);
    bus(1'b1, 4'h1, 32'h120);
    field.press(1'b1);
    check("blocked", ctl.manual_mode, 1'b0);
    field.set_din(7'h1);
    wt();
    check("he", {ctl.manual_mode, ctl.output_freeze}, 2'b11);
    field.set_din(7'h0);
    bus(1'b1, 4'h1, 32'h20);
    field.press(1'b1);
    check("key", ctl.manual_mode, 1'b1);
    field.press(1'b1);
    check("key off", ctl.manual_mode, 1'b0);
    bus(1'b1, 4'h1, 32'h320);
    for (int j = 0; j < 4; j++) begin
      field.set_din(j[0] ? 7'h0 : 7'h1);
      wt();
      check("edge", ctl.manual_mode, j < 2);
    end
    bus(1'b1, 4'h1, 32'h2320);
    bus(1'b1, 4'h3, 32'h2);
    wt();
    check("he gated", ctl.manual_mode, 1'b0);
    bus(1'b1, 4'h1, 32'h2420);
    wt();
    check("he free", ctl.manual_mode, 1'b1);
    $display("manual test done");
    print_verdict();
  end
endmodule
bind csr_routing csr_routing_asserts chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ctl_o(ctl_o));
